// ---- core/config_prom_pkg.sv ----
// shared constants for the serial configuration memory read-out block
// assumes a 250 MHz system clock and a serial clock driven by the loading master
package config_prom_pkg;

  // =====================================================================
  // storage geometry
  // =====================================================================
  localparam int ADDR_W = 20;           // bit address space, top address fffff
  localparam int PAGE_SEL_W = 2;        // four equal pages
  localparam int PAGE_LOW_W = ADDR_W - PAGE_SEL_W;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

  // =====================================================================
  // write buffer between the user port and the serial side
  // =====================================================================
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = ADDR_W + 1;  // bit address plus bit value

  // =====================================================================
  // timing
  // =====================================================================
  localparam int CLK_PERIOD_PS = 4000;  // 250 MHz system clock
  localparam int POR_TIME_NS = 1000;    // power-on reset cycle length
  // least time, rounded up to whole cycles
  localparam int POR_CYCLES = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ---- core/config_write_fifo.sv ----
// dual-clock buffer carrying bit writes from the system clock to the serial clock
// assumes depth is a power of two, at least four; each side has its own sync reset
`timescale 1ns/100ps
`default_nettype none

module config_write_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_n_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_n_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rd_gray_s1;
  logic [AW:0] rd_gray_s2;
  logic [AW:0] wr_gray_s1;
  logic [AW:0] wr_gray_s2;
  logic [AW:0] next_wr_bin;
  logic [AW:0] next_rd_bin;

  // =====================================================================
  // write side
  // =====================================================================
  assign next_wr_bin = wr_bin + 1'b1;
  // full when the far pointer is one lap behind
  assign wr_ready_o = (wr_gray != {~rd_gray_s2[AW:AW-1], rd_gray_s2[AW-2:0]});

  // store a word and move the gray write pointer
  always_ff @(posedge wr_clk_i) begin
    if (!wr_rst_n_i) begin
      wr_bin <= '0;
      wr_gray <= '0;
    end else if (wr_valid_i && wr_ready_o) begin
      mem[wr_bin[AW-1:0]] <= wr_data_i;
      wr_bin <= next_wr_bin;
      wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
    end
  end

  // read pointer into the write domain, two stages
  always_ff @(posedge wr_clk_i) begin
    rd_gray_s1 <= rd_gray;
    rd_gray_s2 <= rd_gray_s1;
  end

  // =====================================================================
  // read side
  // =====================================================================
  assign next_rd_bin = rd_bin + 1'b1;
  assign rd_valid_o = (rd_gray != wr_gray_s2);
  assign rd_data_o = mem[rd_bin[AW-1:0]];

  // drop the head word once taken
  always_ff @(posedge rd_clk_i) begin
    if (!rd_rst_n_i) begin
      rd_bin <= '0;
      rd_gray <= '0;
    end else if (rd_valid_o && rd_ready_i) begin
      rd_bin <= next_rd_bin;
      rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
    end
  end

  // write pointer into the read domain, two stages
  always_ff @(posedge rd_clk_i) begin
    wr_gray_s1 <= wr_gray;
    wr_gray_s2 <= wr_gray_s1;
  end

endmodule // config_write_fifo

`default_nettype wire

// ---- core/serial_config_prom_readout.sv ----
// serial configuration memory: bit store, address counter, paging, cascade hand-off,
// standby, power-on ready indicator and programming-mode writes
// assumes the serial clock and the control pins come from the loading master and
// are set up to the serial clock; user writes arrive on the 250 MHz system clock
//
// How it works
// - data output carries one stored bit per serial clock to the loader
// - read-out advances on the shared serial configuration clock
// - ready pin pulled low during power-on reset, released afterwards
// - clock after the last bit drops cascade output and floats data
// - low chip select from upstream enables data and continues stream
// - reset/output-enable low after configuration resets the address counter
// - serial enable low enters programming mode, memory written instead
// - serial enable high and chip select high means standby, counters halted
// - in standby the data output floats whatever output enable says
// - paging confines read-out to the selected quarter, else full range
// - counting and driving only with chip select low and output enable high
// - reset/output-enable low resets counters and floats data regardless of chip select
// - cascade output falls on the clock after the top address of page or device
`timescale 1ns/100ps
`default_nettype none

module serial_config_prom_readout #(
  parameter int ADDR_W = config_prom_pkg::ADDR_W,
  parameter int POR_CYCLES = config_prom_pkg::POR_CYCLES,
  parameter int FIFO_DEPTH = config_prom_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_config_clock_i,
  input wire logic chip_select_n_i,
  input wire logic reset_oe_i,
  input wire logic serial_enable_n_i,
  input wire logic page_enable_i,
  input wire logic [config_prom_pkg::PAGE_SEL_W-1:0] page_select_i,
  output logic data_o,
  output logic data_oe_o,
  output logic cascade_select_out_n_o,
  output logic ready_o,
  output logic ready_oe_o,
  input wire logic prog_valid_i,
  output logic prog_ready_o,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  input wire logic prog_bit_i,
  output logic standby_o,
  output logic in_system_programming_o
);

  localparam int DEPTH = 2 ** ADDR_W;
  localparam int LOW_W = ADDR_W - config_prom_pkg::PAGE_SEL_W;
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

  // =====================================================================
  // system clock side: power-on reset cycle
  // =====================================================================
  logic [POR_W-1:0] por_cnt;
  logic por_done;

  // count out the power-on reset cycle once after reset release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      por_cnt <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      if (por_cnt == POR_LAST) begin
        por_done <= 1'b1;
      end else begin
        por_cnt <= por_cnt + 1'b1;
      end
    end
  end

  // open-drain ready: pull low until the cycle ends, then let go
  assign ready_o = 1'b0;
  assign ready_oe_o = ~por_done;

  // =====================================================================
  // serial clock side: reset taken from the end of power-on
  // =====================================================================
  logic por_s1;
  logic link_rst_n;

  // power-on done crosses as a level; counters reset until it arrives
  always_ff @(posedge serial_config_clock_i) begin
    por_s1 <= por_done;
    link_rst_n <= por_s1;
  end

  // =====================================================================
  // bit store and programming-mode writes
  // =====================================================================
  logic store [DEPTH];
  logic fifo_valid;
  logic fifo_ready;
  logic [ADDR_W:0] fifo_word;

  config_write_fifo #(
    .WIDTH(ADDR_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .wr_clk_i(clk_i),
    .wr_rst_n_i(rst_n_i),
    .wr_valid_i(prog_valid_i),
    .wr_ready_o(prog_ready_o),
    .wr_data_i({prog_addr_i, prog_bit_i}),
    .rd_clk_i(serial_config_clock_i),
    .rd_rst_n_i(link_rst_n),
    .rd_valid_o(fifo_valid),
    .rd_ready_i(fifo_ready),
    .rd_data_o(fifo_word)
  );

  // writes drain only in programming mode; otherwise the buffer backs up
  assign fifo_ready = link_rst_n & ~serial_enable_n_i;

  // commit one buffered bit per serial clock
  always_ff @(posedge serial_config_clock_i) begin
    if (fifo_valid && fifo_ready) begin
      store[fifo_word[ADDR_W:1]] <= fifo_word[0];
    end
  end

  // =====================================================================
  // page window
  // =====================================================================
  logic [ADDR_W-1:0] page_base;
  logic [ADDR_W-1:0] page_top;

  // quarter of the space chosen by page select, or the whole device
  always_comb begin
    if (page_enable_i) begin
      page_base = {page_select_i, {LOW_W{1'b0}}};
      page_top = {page_select_i, {LOW_W{1'b1}}};
    end else begin
      page_base = ADDR_W'(config_prom_pkg::ADDR_RESET);
      page_top = {ADDR_W{1'b1}};
    end
  end

  // =====================================================================
  // address counter and serial data
  // =====================================================================
  logic [ADDR_W-1:0] ptr; // bit address into the store, one stored bit per value
  logic last_out;
  logic done;
  logic data_q;
  logic active;
  logic counter_clear;

  assign counter_clear = serial_enable_n_i & ~reset_oe_i;
  // counting and driving need chip select low and output enable high
  assign active = serial_enable_n_i & ~chip_select_n_i & reset_oe_i & ~done;

  // one bit per enabled edge; the edge after the last bit ends the stream
  always_ff @(posedge serial_config_clock_i) begin
    if (!link_rst_n) begin
      ptr <= page_base;
      last_out <= 1'b0;
      done <= 1'b0;
      data_q <= 1'b0;
    end else if (counter_clear) begin
      ptr <= page_base;
      last_out <= 1'b0;
      done <= 1'b0;
    end else if (active) begin
      if (last_out) begin
        done <= 1'b1;
      end else begin
        data_q <= store[ptr];
        if (ptr == page_top) begin
          last_out <= 1'b1;
        end else begin
          ptr <= ptr + 1'b1;
        end
      end
    end
  end

  // driver on only while reading; floats in standby, reset and after hand-off
  assign data_o = data_q;
  assign data_oe_o = active;
  // low once done while selected; follows chip select until output enable drops
  assign cascade_select_out_n_o =
    ~(done & ~chip_select_n_i & reset_oe_i & serial_enable_n_i);

  // =====================================================================
  // status levels back to the system clock
  // =====================================================================
  logic standby_q;
  logic standby_s1;
  logic prog_s1;

  // standby: serial enable high and chip select high
  always_ff @(posedge serial_config_clock_i) begin
    if (!link_rst_n) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= serial_enable_n_i & chip_select_n_i;
    end
  end

  // two-stage synchronisers for the status outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      standby_s1 <= 1'b0;
      standby_o <= 1'b0;
      prog_s1 <= 1'b0;
      in_system_programming_o <= 1'b0;
    end else begin
      standby_s1 <= standby_q;
      standby_o <= standby_s1;
      prog_s1 <= ~serial_enable_n_i;
      in_system_programming_o <= prog_s1;
    end
  end

  // =====================================================================
  // checks on the serial clock side, ready checks on the system clock
  // =====================================================================
  a_standby_halts: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    serial_enable_n_i && chip_select_n_i && reset_oe_i |-> !data_oe_o ##1 $stable(ptr))
    else $error("counter moved or driver on in standby");

  a_reset_clears: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    serial_enable_n_i && !reset_oe_i |-> !data_oe_o ##1 (ptr == $past(page_base)) && !done)
    else $error("reset did not clear counter or float data");

  a_advance_one: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    active && !last_out && ptr != page_top |=> ptr == $past(ptr) + 1'b1)
    else $error("counter did not advance by one");

  a_data_from_store: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    active && !last_out |=> data_o == store[$past(ptr)])
    else $error("data bit does not match stored bit");

  a_handoff_edge: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    active && last_out ##1 (serial_enable_n_i && !chip_select_n_i && reset_oe_i)
    |-> !cascade_select_out_n_o && !data_oe_o)
    else $error("no hand-off on clock after last bit");

  a_page_window: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    data_oe_o && $stable(page_base) |-> ptr >= page_base && ptr <= page_top)
    else $error("read-out left the selected page");

  a_done_at_top: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    $rose(done) |-> ptr == $past(page_top) && $past(last_out))
    else $error("stream ended away from the top address");

  a_follow_select: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    done && chip_select_n_i |-> cascade_select_out_n_o && !data_oe_o)
    else $error("cascade output did not follow chip select");

  a_prog_quiet: assert property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    !serial_enable_n_i |-> !data_oe_o && cascade_select_out_n_o && fifo_ready)
    else $error("read-out active in programming mode");

  a_ready_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !por_done |-> ready_oe_o && !ready_o ##1 (por_done || por_cnt == $past(por_cnt) + 1'b1))
    else $error("ready released early or counter stuck");

  a_ready_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(por_done) |-> $past(por_cnt) == POR_LAST && !ready_oe_o)
    else $error("ready released at wrong count");

  c_cascade_handoff: cover property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    $fell(cascade_select_out_n_o));

  c_paged_read: cover property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    data_oe_o && page_enable_i && page_select_i == 2'h3);

  c_prog_write: cover property (@(posedge serial_config_clock_i) disable iff (!link_rst_n)
    fifo_valid && fifo_ready);

  c_ready_release: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(por_done));

endmodule // serial_config_prom_readout

`default_nettype wire

// ---- verification/config_loader_model.sv ----
// loader-side model: makes the serial clock in bursts and samples the data pin
// assumes the bench raises an edge target; the clock stands low between bursts
`timescale 1ns/100ps
`default_nettype none

module config_loader_model (
  input wire logic [15:0] edge_target_i,
  input wire logic data_i,
  input wire logic data_oe_i,
  output logic serial_config_clock_o,
  output logic [15:0] edge_count_o
);
  // =====================================================================
  // pin level and burst clock
  // =====================================================================
  logic rx_line [0:255];
  logic line;

  // released data pin floats up to the pull-up level
  assign line = data_oe_i ? data_i : 1'b1;

  // one 6 ns pulse per pending edge, 12 ns apart, odd phase to the system clock
  initial begin
    serial_config_clock_o = 1'b0;
    edge_count_o = 16'h0000;
    forever begin
      wait (edge_count_o != edge_target_i);
      #1.3;
      serial_config_clock_o = 1'b1;
      edge_count_o = edge_count_o + 16'h0001;
      #6;
      serial_config_clock_o = 1'b0;
      #4.7;
    end
  end

  // one configuration bit taken per clock, once settled
  always @(negedge serial_config_clock_o) begin
    rx_line[edge_count_o[7:0]] <= line;
  end
endmodule // config_loader_model
`default_nettype wire

// ---- verification/serial_config_prom_readout_tb.sv ----
// self-checking bench: programs a small store, reads it back page by page
// assumes a 6-bit address build of the block and the loader model beside it
`timescale 1ns/100ps
`default_nettype none

module serial_config_prom_readout_tb;
  // =====================================================================
  // signals and instances
  // =====================================================================
  localparam int AW = 6;
  localparam logic [63:0] MEM = 64'hc3a5_1e96_7d20_f04b;
  logic clk_i, rst_n_i, sclk, cs_n, oe, serial_enable_n_n, pg_en, pv, pr, pbit;
  logic data, data_oe, casc_n, rdy, rdy_oe, stby, in_system_programming;
  logic [1:0] pg_sel;
  logic [AW-1:0] paddr;
  logic [15:0] tgt, ecnt;
  int err_total, n_checks, base, n;

  serial_config_prom_readout #(.ADDR_W(AW), .POR_CYCLES(4)) serial_config_prom_readout_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .serial_config_clock_i(sclk),
    .chip_select_n_i(cs_n), .reset_oe_i(oe), .serial_enable_n_i(serial_enable_n_n),
    .page_enable_i(pg_en), .page_select_i(pg_sel), .data_o(data), .data_oe_o(data_oe),
    .cascade_select_out_n_o(casc_n), .ready_o(rdy), .ready_oe_o(rdy_oe),
    .prog_valid_i(pv), .prog_ready_o(pr), .prog_addr_i(paddr), .prog_bit_i(pbit),
    .standby_o(stby), .in_system_programming_o(in_system_programming));

  config_loader_model config_loader_model_inst (
    .edge_target_i(tgt), .data_i(data), .data_oe_i(data_oe),
    .serial_config_clock_o(sclk), .edge_count_o(ecnt));

  // =====================================================================
  // tasks
  // =====================================================================
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // runs a burst of serial edges and waits for it to land
  task automatic run(input int cnt);
    int k;
    k = 0;
    @(posedge clk_i);
    tgt <= tgt + 16'(cnt);
    do begin
      @(posedge clk_i);
      k++;
    end while (ecnt !== tgt && k < 3 * cnt + 20);
    if (ecnt !== tgt) chk(ecnt, tgt);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic pins(input logic c, input logic o, input logic s);
    @(posedge clk_i);
    cs_n <= c;
    oe <= o;
    serial_enable_n_n <= s;
    @(negedge clk_i);
  endtask

  // one bit write; called at a clock edge, leaves valid up for back to back use
  task automatic wr(input logic [AW-1:0] a, input logic b);
    int k;
    k = 0;
    pv <= 1'b1;
    paddr <= a;
    pbit <= b;
    do begin
      @(posedge clk_i);
      k++;
    end while (pr !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
  endtask

  // =====================================================================
  // clock, watchdog and test sequence
  // =====================================================================
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // cuts a hang short well past the expected run length
  initial begin
    #100000;
    err_total++;
    final_report();
  end

  initial begin
    rst_n_i = 1'b0; cs_n = 1'b1; oe = 1'b1; serial_enable_n_n = 1'b1; pg_en = 1'b0;
    pg_sel = 2'h0; pv = 1'b0; paddr = '0; pbit = 1'b0; tgt = 16'h0000;
    err_total = 0;
    n_checks = 0;
    // serial edges inside reset so the link side takes its own reset
    @(posedge clk_i);
    tgt <= 16'h0003;
    repeat (9) @(posedge clk_i);
    @(negedge clk_i);
    chk(rdy_oe, 1);
    chk(rdy, 0);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk(rdy_oe, 0);
    chk(ecnt, 3);
    run(3);
    // programming mode: fill the buffer while the serial clock stands still
    pins(1'b1, 1'b1, 1'b0);
    repeat (3) @(negedge clk_i);
    chk(in_system_programming, 1);
    chk(data_oe, 0);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      for (int j = 0; j < 8; j++) wr(6'(c * 8 + j), MEM[c * 8 + j]);
      pv <= 1'b0;
      if (c == 0) begin
        repeat (2) @(negedge clk_i);
        chk(pr, 0);
      end
      run(14);
    end
    // four pages, then the whole store as one stream
    for (int p = 0; p < 5; p++) begin
      @(posedge clk_i);
      pg_en <= (p < 4);
      pg_sel <= p[1:0];
      pins(1'b0, 1'b0, 1'b1);
      run(1);
      chk(data_oe, 0);
      pins(1'b0, 1'b1, 1'b1);
      base = int'(tgt);
      n = (p < 4) ? 16 : 64;
      run(n);
      for (int i = 0; i < n; i++)
        chk(config_loader_model_inst.rx_line[8'(base + 1 + i)], MEM[(p % 4) * 16 + i]);
      chk(casc_n, 1);
      chk(data_oe, 1);
      run(1);
      chk(casc_n, 0);
      chk(data_oe, 0);
    end
    // cascade output follows chip select until the counter is reset
    pins(1'b1, 1'b1, 1'b1);
    chk(casc_n, 1);
    pins(1'b0, 1'b1, 1'b1);
    chk(casc_n, 0);
    pins(1'b0, 1'b0, 1'b1);
    run(1);
    chk(casc_n, 1);
    chk(data_oe, 0);
    // standby in mid-stream halts the counter and floats the data pin
    pins(1'b0, 1'b1, 1'b1);
    base = int'(tgt);
    run(5);
    chk(stby, 0);
    pins(1'b1, 1'b1, 1'b1);
    chk(data_oe, 0);
    run(4);
    chk(stby, 1);
    pins(1'b0, 1'b1, 1'b1);
    run(3);
    for (int i = 0; i < 3; i++)
      chk(config_loader_model_inst.rx_line[8'(base + 10 + i)], MEM[5 + i]);
    final_report();
  end
endmodule // serial_config_prom_readout_tb
`default_nettype wire
